/* File: frame_readout_context_control.sv */
// module: rolling readout sequencer with hdr, shutter, context switching and apb registers
`timescale 1ns/1ns
// Contract
// - default first pixel is column 10, row 14
// - mirrored readout uses extra rows and columns
// - output one complete row at a time
// - linear after reset, hdr only when configured
// - hdr keeps two interleaved reset/read pointer pairs
// - ratio choices 4x, 8x, 16x, 32x
// - arbitrary ratio via second exposure row count
// - hdr outputs both, first only or second only
// - rolling mode resets then reads each row
// - reset-to-read interval equal for every row
// - exposure change staged at frame boundary
// - global reset single frame with shutter control
// - embedded data two rows before image
// - statistics two rows after image
// - slave mode frame starts only on trigger; in global mode the grab bit starts the frame without a trigger
// - context memory 256 entries of 16 bits
// - context bit selects register set a or b
// - exposure in n+1, others in n+2
// - analogue gain global, digital gain per channel
// - separate analogue gain per exposure in hdr
// - hdr exposures sent as separate interleaved lines
module frame_readout_context_control
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger,
  output logic shutter_open,
  output logic row_reset,
  output logic [11:0] reset_row,
  output readout_pkg::pixel_s pixel
);
  typedef enum logic [5:0]
  {
    st_idle = 6'b000001,
    st_shutter = 6'b000010,
    st_head = 6'b000100,
    st_image = 6'b001000,
    st_tail = 6'b010000,
    st_gap = 6'b100000
  } state_e;

  state_e state;
  state_e next_state;
  logic [31:0] ctrl;
  logic [31:0] exp_a;
  logic [31:0] exp_b;
  logic [31:0] frame_a;
  logic [31:0] frame_b;
  logic [31:0] gain_a;
  logic [31:0] gain_b;
  logic [31:0] dgain_a;
  logic [31:0] dgain_b;
  logic [7:0] ctx_ptr;
  logic [15:0] ctx_mem [0:255];
  logic [15:0] ctx_rdata;
  logic ctx_sel_frame;
  logic ctx_sel_prev;
  logic hdr_frame;
  logic [1:0] out_sel_frame;
  readout_pkg::ctx_s exp_set;
  readout_pkg::ctx_s geo_set;
  logic [15:0] row_cnt;
  logic [15:0] col_cnt;
  logic hdr_phase;
  logic [2:0] extra_cnt;
  logic [31:0] shut_cnt;
  logic [15:0] frame_count;
  logic [15:0] rst_ptr_first;
  logic [15:0] rst_ptr_second;

  // bus decode
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_ctrl = paddr == readout_pkg::ctrl_addr;
  wire hit_status = paddr == readout_pkg::status_addr;
  wire hit_exp_a = paddr == readout_pkg::exp_a_addr;
  wire hit_exp_b = paddr == readout_pkg::exp_b_addr;
  wire hit_frame_a = paddr == readout_pkg::frame_a_addr;
  wire hit_frame_b = paddr == readout_pkg::frame_b_addr;
  wire hit_gain_a = paddr == readout_pkg::gain_a_addr;
  wire hit_gain_b = paddr == readout_pkg::gain_b_addr;
  wire hit_dgain_a = paddr == readout_pkg::dgain_a_addr;
  wire hit_dgain_b = paddr == readout_pkg::dgain_b_addr;
  wire hit_ctx_addr = paddr == readout_pkg::ctx_addr_addr;
  wire hit_ctx_data = paddr == readout_pkg::ctx_data_addr;
  wire hit_position = paddr == readout_pkg::position_addr;
  wire hit_any = hit_ctrl | hit_status | hit_exp_a | hit_exp_b | hit_frame_a | hit_frame_b
    | hit_gain_a | hit_gain_b | hit_dgain_a | hit_dgain_b | hit_ctx_addr | hit_ctx_data
    | hit_position;

  assign pready = 1'b1;
  assign pslverr = access & ~hit_any;

  // control fields
  wire streaming = ctrl[readout_pkg::ctrl_stream_bit];
  wire hdr_on = hdr_frame; // mode held for a whole frame
  wire [1:0] out_sel = out_sel_frame;
  wire [1:0] ratio_sel = ctrl[readout_pkg::ctrl_ratio_lsb +: 2];
  wire free_ratio = ctrl[readout_pkg::ctrl_free_ratio_bit];
  wire mirror = ctrl[readout_pkg::ctrl_mirror_bit];
  wire emb_data = ctrl[readout_pkg::ctrl_emb_data_bit];
  wire emb_stats = ctrl[readout_pkg::ctrl_emb_stats_bit];
  wire slave = ctrl[readout_pkg::ctrl_slave_bit];
  wire global_mode = ctrl[readout_pkg::ctrl_global_bit];
  wire ctx_sel_req = ctrl[readout_pkg::ctrl_ctx_sel_bit];
  wire grab = ctrl[readout_pkg::ctrl_grab_bit];

  // next frame's sets: exposure takes the new select, the rest the one before
  wire [31:0] live_exp = ctx_sel_req ? exp_b : exp_a;
  wire [31:0] live_frame = ctx_sel_frame ? frame_b : frame_a;
  wire [31:0] live_gain = ctx_sel_frame ? gain_b : gain_a;
  wire [31:0] live_dgain = ctx_sel_frame ? dgain_b : dgain_a;

  // second exposure rows: fixed ratio or free count
  wire [15:0] ratio_rows = live_exp[15:0] >> (3'd2 + {1'b0, ratio_sel});
  wire [15:0] second_rows = free_ratio ? live_exp[31:16] : ratio_rows;

  // frame boundary: leaving idle, gap or shutter
  wire frame_start = (state == st_idle || state == st_gap || state == st_shutter)
    && next_state == st_head;
  wire last_row = row_cnt == geo_set.rows - 16'h0001;
  wire last_col = col_cnt == geo_set.cols - 16'h0001;
  wire hdr_second_done = ~hdr_on | hdr_phase;
  wire row_done = last_col & hdr_second_done;
  wire start_ok = slave ? trigger : 1'b1;
  wire shut_done = shut_cnt == readout_pkg::shutter_cycles - 1;

  // readout sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
        if (global_mode)
        begin
          if (grab)
            next_state = st_shutter;
        end
        else if (streaming && start_ok)
          next_state = st_head;
      st_shutter:
        if (shut_done)
          next_state = st_head;
      st_head:
        if (!emb_data || (extra_cnt == readout_pkg::emb_rows - 3'h1 && last_col))
          next_state = st_image;
      st_image:
        if (last_row && row_done)
          next_state = emb_stats ? st_tail : st_gap;
      st_tail:
        if (extra_cnt == readout_pkg::emb_rows - 3'h1 && last_col)
          next_state = st_gap;
      st_gap:
        if (global_mode || !streaming)
          next_state = st_idle;
        else if (start_ok)
          next_state = st_head;
      default:
        next_state = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= st_idle;
    else
      state <= next_state;
  end

  // register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= readout_pkg::ctrl_reset;
      exp_a <= readout_pkg::exp_reset;
      exp_b <= readout_pkg::exp_reset;
      frame_a <= readout_pkg::frame_reset;
      frame_b <= readout_pkg::frame_reset;
      gain_a <= readout_pkg::gain_reset;
      gain_b <= readout_pkg::gain_reset;
      dgain_a <= readout_pkg::dgain_reset;
      dgain_b <= readout_pkg::dgain_reset;
      ctx_ptr <= 8'h00;
    end
    else
    begin
      if (wr && hit_ctrl)
        ctrl <= pwdata;
      else if (state == st_shutter && shut_done)
        ctrl[readout_pkg::ctrl_grab_bit] <= 1'b0; // one frame per grab
      if (wr && hit_exp_a)
        exp_a <= pwdata;
      if (wr && hit_exp_b)
        exp_b <= pwdata;
      if (wr && hit_frame_a)
        frame_a <= pwdata;
      if (wr && hit_frame_b)
        frame_b <= pwdata;
      if (wr && hit_gain_a)
        gain_a <= pwdata;
      if (wr && hit_gain_b)
        gain_b <= pwdata;
      if (wr && hit_dgain_a)
        dgain_a <= pwdata;
      if (wr && hit_dgain_b)
        dgain_b <= pwdata;
      if (wr && hit_ctx_addr)
        ctx_ptr <= pwdata[7:0];
      else if (access && hit_ctx_data)
        ctx_ptr <= ctx_ptr + 8'h01; // auto increment
    end
  end

  // context memory, no reset on storage
  always_ff @(posedge pclk)
  begin
    if (wr && hit_ctx_data)
      ctx_mem[ctx_ptr] <= pwdata[15:0];
  end
  assign ctx_rdata = ctx_mem[ctx_ptr];

  // context and exposure staging at frame boundaries
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctx_sel_frame <= 1'b0;
      ctx_sel_prev <= 1'b0;
      exp_set <= '0;
      geo_set <= '0;
      hdr_frame <= 1'b0;
      out_sel_frame <= 2'h0;
    end
    else if (frame_start)
    begin
      ctx_sel_frame <= ctx_sel_req;
      ctx_sel_prev <= ctx_sel_frame;
      // exposure follows the selection one frame later
      exp_set.exp_first <= live_exp[15:0];
      exp_set.exp_second <= second_rows;
      // frame size and gains lag one more frame; hdr mode and output select come from ctrl at this boundary
      geo_set.rows <= live_frame[15:0]
        + (mirror ? {4'h0, readout_pkg::extra_pix} : 16'h0000);
      geo_set.cols <= live_frame[31:16]
        + (mirror ? {4'h0, readout_pkg::extra_pix} : 16'h0000);
      geo_set.gain_first <= live_gain[7:0];
      geo_set.gain_second <= live_gain[15:8];
      geo_set.dgain <= live_dgain;
      hdr_frame <= ctrl[readout_pkg::ctrl_hdr_bit];
      out_sel_frame <= ctrl[readout_pkg::ctrl_out_sel_lsb +: 2];
    end
  end

  // row, column and extra-row counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      col_cnt <= 16'h0000;
      row_cnt <= 16'h0000;
      hdr_phase <= 1'b0;
      extra_cnt <= 3'h0;
    end
    else if (state == st_image)
    begin
      col_cnt <= last_col ? 16'h0000 : col_cnt + 16'h0001;
      if (last_col)
        hdr_phase <= hdr_on & ~hdr_phase;
      if (row_done)
        row_cnt <= last_row ? 16'h0000 : row_cnt + 16'h0001;
    end
    else if (state == st_head || state == st_tail)
    begin
      // image always starts at column zero
      col_cnt <= (last_col || next_state != state) ? 16'h0000 : col_cnt + 16'h0001;
      if (last_col)
        extra_cnt <= (next_state == state) ? extra_cnt + 3'h1 : 3'h0;
    end
    else
    begin
      col_cnt <= 16'h0000;
      row_cnt <= 16'h0000;
      hdr_phase <= 1'b0;
      extra_cnt <= 3'h0;
    end
  end

  // reset pointers lead the read pointer by the exposure rows
  always_comb
  begin
    rst_ptr_first = row_cnt + exp_set.exp_first;
    rst_ptr_second = row_cnt + exp_set.exp_second;
  end

  // shutter timer and frame counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shut_cnt <= 32'h0;
      frame_count <= 16'h0000;
    end
    else
    begin
      shut_cnt <= (state == st_shutter) ? shut_cnt + 32'h1 : 32'h0;
      if (frame_start)
        frame_count <= frame_count + 16'h0001;
    end
  end

  // stream outputs
  wire mirror_off = mirror;
  wire [11:0] out_row = row_cnt[11:0] + readout_pkg::first_row + (mirror_off ? 12'h000 : 12'h000);
  wire [11:0] out_col = col_cnt[11:0] + readout_pkg::first_col;
  wire show_line = ~hdr_on || out_sel == readout_pkg::out_both
    || (out_sel == readout_pkg::out_first && !hdr_phase)
    || (out_sel == readout_pkg::out_second && hdr_phase);
  wire in_frame = state == st_head || state == st_image || state == st_tail;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pixel <= '0;
      shutter_open <= 1'b0;
      row_reset <= 1'b0;
      reset_row <= 12'h000;
    end
    else
    begin
      pixel.frame_valid <= in_frame;
      pixel.line_valid <= in_frame
        && (state == st_image ? show_line : (state != st_head || emb_data));
      pixel.kind <= state == st_head ? readout_pkg::line_embedded
        : state == st_tail ? readout_pkg::line_stats
        : hdr_phase ? readout_pkg::line_image_second : readout_pkg::line_image_first;
      pixel.col <= out_col;
      pixel.row <= state == st_image ? out_row : {9'h000, extra_cnt};
      pixel.again <= hdr_phase ? geo_set.gain_second : geo_set.gain_first;
      pixel.dgain <= geo_set.dgain[{row_cnt[0], col_cnt[0], 3'h0} +: 8];
      shutter_open <= state == st_shutter;
      row_reset <= state == st_image && last_col && !global_mode;
      reset_row <= (hdr_phase ? rst_ptr_second[11:0] : rst_ptr_first[11:0])
        + readout_pkg::first_row;
    end
  end

  // read mux
  always_comb
  begin
    prdata = 32'h0;
    if (hit_ctrl)
      prdata = ctrl;
    else if (hit_status)
      prdata = {frame_count, 8'h00, 1'b0, ctx_sel_prev, ctx_sel_frame, state[5:1]};
    else if (hit_exp_a)
      prdata = exp_a;
    else if (hit_exp_b)
      prdata = exp_b;
    else if (hit_frame_a)
      prdata = frame_a;
    else if (hit_frame_b)
      prdata = frame_b;
    else if (hit_gain_a)
      prdata = gain_a;
    else if (hit_gain_b)
      prdata = gain_b;
    else if (hit_dgain_a)
      prdata = dgain_a;
    else if (hit_dgain_b)
      prdata = dgain_b;
    else if (hit_ctx_addr)
      prdata = {24'h0, ctx_ptr};
    else if (hit_ctx_data)
      prdata = {16'h0, ctx_rdata};
    else if (hit_position)
      prdata = {row_cnt, col_cnt};
  end
endmodule : frame_readout_context_control

/* File: readout_pkg.sv */
// package: register map, fields, reset values, timing and carriers for the readout block
package readout_pkg;
  // register byte offsets
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] exp_a_addr = 12'h008;
  localparam logic [11:0] exp_b_addr = 12'h00c;
  localparam logic [11:0] frame_a_addr = 12'h010;
  localparam logic [11:0] frame_b_addr = 12'h014;
  localparam logic [11:0] gain_a_addr = 12'h018;
  localparam logic [11:0] gain_b_addr = 12'h01c;
  localparam logic [11:0] dgain_a_addr = 12'h020;
  localparam logic [11:0] dgain_b_addr = 12'h024;
  localparam logic [11:0] ctx_addr_addr = 12'h028;
  localparam logic [11:0] ctx_data_addr = 12'h02c;
  localparam logic [11:0] position_addr = 12'h030;
  // control register fields
  localparam int ctrl_stream_bit = 0;
  localparam int ctrl_hdr_bit = 1;
  localparam int ctrl_out_sel_lsb = 2;
  localparam int ctrl_ratio_lsb = 4;
  localparam int ctrl_free_ratio_bit = 6;
  localparam int ctrl_mirror_bit = 7;
  localparam int ctrl_emb_data_bit = 8;
  localparam int ctrl_emb_stats_bit = 9;
  localparam int ctrl_slave_bit = 10;
  localparam int ctrl_global_bit = 11;
  localparam int ctrl_ctx_sel_bit = 12;
  localparam int ctrl_grab_bit = 13;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  // exposure register: first in low half, second in high half
  localparam logic [31:0] exp_reset = 32'h0004_0010;
  // frame register: active rows in low half, columns in high half
  localparam logic [31:0] frame_reset = 32'h0010_0008;
  localparam logic [31:0] gain_reset = 32'h0000_1010;
  localparam logic [31:0] dgain_reset = 32'h1010_1010;
  // first pixel coordinate, default readout
  localparam logic [11:0] first_col = 12'h00a;
  localparam logic [11:0] first_row = 12'h00e;
  localparam logic [11:0] extra_pix = 12'h001;
  // extra rows around the image
  localparam logic [2:0] emb_rows = 3'h2;
  // mechanical shutter exposure in microseconds, and cycles at 20 MHz
  localparam int shutter_us = 100;
  localparam int clk_mhz = 20;
  localparam int shutter_cycles = shutter_us * clk_mhz;
  // output selection
  localparam logic [1:0] out_both = 2'h0;
  localparam logic [1:0] out_first = 2'h1;
  localparam logic [1:0] out_second = 2'h2;
  // line kind tag on the stream
  typedef enum logic [2:0]
  {
    line_image_first = 3'h0,
    line_image_second = 3'h1,
    line_embedded = 3'h2,
    line_stats = 3'h3
  } line_kind_e;
  // pixel stream carrier
  typedef struct packed
  {
    logic frame_valid;
    logic line_valid;
    line_kind_e kind;
    logic [11:0] col;
    logic [11:0] row;
    logic [7:0] again;
    logic [7:0] dgain;
  } pixel_s;
  // per-context settings set
  typedef struct packed
  {
    logic [15:0] exp_first;
    logic [15:0] exp_second;
    logic [15:0] rows;
    logic [15:0] cols;
    logic [7:0] gain_first;
    logic [7:0] gain_second;
    logic [31:0] dgain;
  } ctx_s;
endpackage : readout_pkg

/* File: frame_readout_context_control_checker.sv */
// checker: port-level assertions for the readout sequencer
`timescale 1ns/1ns
module frame_readout_context_control_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger,
  input wire logic shutter_open,
  input wire logic row_reset,
  input wire readout_pkg::pixel_s pixel
);
  logic [31:0] ctrl_q;
  logic [31:0] lat_q;
  logic [31:0] cur;
  logic fv_q;
  logic seen_img;
  logic lv;
  logic hdr;
  logic [1:0] osel;
  logic mapped;
  int sh_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // control settings in force for the frame on the wire
  assign cur = (pixel.frame_valid && !fv_q) ? ctrl_q : lat_q;
  assign hdr = cur[readout_pkg::ctrl_hdr_bit];
  assign osel = cur[readout_pkg::ctrl_out_sel_lsb +: 2];
  assign lv = pixel.line_valid;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= readout_pkg::position_addr;
  // control shadow, frame snapshot, first-pixel flag, shutter length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= 32'h0;
      lat_q <= 32'h0;
      fv_q <= 1'b0;
      seen_img <= 1'b0;
      sh_cnt <= 0;
    end
    else
    begin
      if (psel && penable && pwrite && paddr == readout_pkg::ctrl_addr)
        ctrl_q <= pwdata;
      if (pixel.frame_valid && !fv_q)
        lat_q <= ctrl_q;
      fv_q <= pixel.frame_valid;
      seen_img <= pixel.frame_valid
        && (seen_img || (lv && pixel.kind == readout_pkg::line_image_first));
      sh_cnt <= shutter_open ? sh_cnt + 1 : 0;
    end
  end
  chk_apb_answer:
    assert property (psel && penable |-> pready && pslverr == !mapped)
      else $error("apb answer wrong");
  chk_line_frame:
    assert property (lv |-> pixel.frame_valid) else $error("line outside frame");
  chk_linear_only:
    assert property (lv && !hdr |-> pixel.kind != readout_pkg::line_image_second)
      else $error("second exposure in linear mode");
  chk_out_select:
    assert property (lv && hdr && osel != readout_pkg::out_both |-> pixel.kind !=
      (osel == readout_pkg::out_first ? readout_pkg::line_image_second
      : readout_pkg::line_image_first)) else $error("hidden exposure shown");
  chk_first_pixel:
    assert property (lv && pixel.kind == readout_pkg::line_image_first && !seen_img
      && !cur[readout_pkg::ctrl_mirror_bit] |-> pixel.col == readout_pkg::first_col
      && pixel.row == readout_pkg::first_row) else $error("first pixel wrong");
  chk_emb_gate:
    assert property (lv && pixel.kind == readout_pkg::line_embedded
      |-> cur[readout_pkg::ctrl_emb_data_bit]) else $error("embedded row not enabled");
  chk_stats_gate:
    assert property (lv && pixel.kind == readout_pkg::line_stats
      |-> cur[readout_pkg::ctrl_emb_stats_bit]) else $error("stats row not enabled");
  chk_slave_start:
    assert property ($rose(pixel.frame_valid) && ctrl_q[readout_pkg::ctrl_slave_bit]
      |-> $past(trigger) || $past(trigger, 2) || $past(trigger, 3))
      else $error("slave frame without trigger");
  chk_shutter_len:
    assert property ($fell(shutter_open) |-> sh_cnt == readout_pkg::shutter_cycles)
      else $error("shutter time wrong");
  chk_shutter_mode:
    assert property (shutter_open |-> ctrl_q[readout_pkg::ctrl_global_bit])
      else $error("shutter outside global mode");
  chk_row_pulse:
    assert property (row_reset |=> !row_reset) else $error("row reset not a pulse");
  cover property (lv && pixel.kind == readout_pkg::line_image_second);
  cover property (lv && pixel.kind == readout_pkg::line_embedded);
  cover property ($fell(shutter_open));
  cover property ($rose(pixel.frame_valid) && ctrl_q[readout_pkg::ctrl_slave_bit]);
endmodule : frame_readout_context_control_checker

bind frame_readout_context_control frame_readout_context_control_checker u_chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .trigger, .shutter_open, .row_reset, .pixel
);

/* File: stream_sink_model.sv */
// stream sink: image processor that tallies each frame and paces the trigger
`timescale 1ns/1ns
module stream_sink_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire readout_pkg::pixel_s pixel,
  input wire logic fire,
  output logic trigger,
  output int frames,
  output int tally [4],
  output logic [31:0] first_px,
  output logic [15:0] gains,
  output logic order_bad
);
  int run [4];
  logic fv_q;
  logic img_seen;
  logic st_seen;
  logic bad;
  logic [1:0] got;
  logic [31:0] px_r;
  logic [15:0] gn_r;
  // per-frame tally, ordering watch and one-cycle trigger
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trigger <= 1'b0;
      frames = 0;
      fv_q = 1'b0;
    end
    else
    begin
      trigger <= fire;
      if (pixel.frame_valid && !fv_q)
      begin
        run = '{default: 0};
        img_seen = 1'b0;
        st_seen = 1'b0;
        bad = 1'b0;
        got = 2'h0;
      end
      if (pixel.line_valid)
      begin
        if (pixel.kind == readout_pkg::line_image_first && !got[0])
        begin
          px_r = {8'h0, pixel.col, pixel.row};
          gn_r[7:0] = pixel.again;
          got[0] = 1'b1;
        end
        if (pixel.kind == readout_pkg::line_image_second && !got[1])
        begin
          gn_r[15:8] = pixel.again;
          got[1] = 1'b1;
        end
        bad = bad || (pixel.kind == readout_pkg::line_embedded && img_seen)
          || (pixel.kind <= readout_pkg::line_image_second && st_seen);
        img_seen = img_seen || pixel.kind <= readout_pkg::line_image_second;
        st_seen = st_seen || pixel.kind == readout_pkg::line_stats;
        run[pixel.kind]++;
      end
      if (!pixel.frame_valid && fv_q)
      begin
        tally = run;
        first_px = px_r;
        gains = gn_r;
        order_bad = bad;
        frames++;
      end
      fv_q = pixel.frame_valid;
    end
  end
endmodule : stream_sink_model

/* File: tb_frame_readout_context_control.sv */
// testbench: registers, stream modes, slave, shutter and context switching
`timescale 1ns/1ns
module tb_frame_readout_context_control;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trigger;
  logic fire;
  logic shutter_open;
  logic row_reset;
  readout_pkg::pixel_s pixel;
  int frames;
  int tally [4];
  logic [31:0] first_px;
  logic [15:0] gains;
  logic order_bad;
  int num_errors;
  int samples_checked;
  logic [31:0] rd;
  logic er;
  logic [31:0] g;
  int f;
  int exp_q [$];
  logic [11:0] ra [9] = '{12'h000, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c,
    12'h020, 12'h024};
  logic [31:0] rv [9] = '{readout_pkg::ctrl_reset, readout_pkg::exp_reset,
    readout_pkg::exp_reset, readout_pkg::frame_reset, readout_pkg::frame_reset,
    readout_pkg::gain_reset, readout_pkg::gain_reset, readout_pkg::dgain_reset,
    readout_pkg::dgain_reset};
  logic [31:0] modes [6] = '{32'h301, 32'h81, 32'h03, 32'h17, 32'h6b, 32'h133};
  frame_readout_context_control u_dut
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .trigger, .shutter_open, .row_reset, .reset_row(), .pixel
  );
  stream_sink_model u_sink
  (
    .pclk, .presetn, .pixel, .fire, .trigger, .frames, .tally, .first_px, .gains,
    .order_bad
  );
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_frames(input int k);
    int f0;
    f0 = frames;
    for (int n = 0; n < 40000 && frames < f0 + k; n++) @(negedge pclk);
    if (frames < f0 + k) chk(frames, f0 + k);
  endtask : wait_frames
  task automatic stop;
    apb(1'b1, readout_pkg::ctrl_addr, 32'h0);
    for (int n = 0; n < 5000 && pixel.frame_valid !== 1'b0; n++) @(negedge pclk);
    if (pixel.frame_valid !== 1'b0) chk(32'(pixel.frame_valid), 32'h0);
    repeat (4) @(negedge pclk);
  endtask : stop
  // frame model: counts per line kind from the mode and 8 rows of 16 columns
  task automatic check_frame(input logic [31:0] c);
    logic h;
    logic [1:0] o;
    int r;
    int w;
    h = c[readout_pkg::ctrl_hdr_bit];
    o = c[readout_pkg::ctrl_out_sel_lsb +: 2];
    // mirrored readout adds the extra row and column
    r = readout_pkg::frame_reset[15:0] + (c[readout_pkg::ctrl_mirror_bit] ? 1 : 0);
    w = readout_pkg::frame_reset[31:16] + (c[readout_pkg::ctrl_mirror_bit] ? 1 : 0);
    chk(tally[0], (!h || o != readout_pkg::out_second) ? r * w : 0);
    chk(tally[1], (h && o != readout_pkg::out_first) ? r * w : 0);
    chk(tally[2], c[readout_pkg::ctrl_emb_data_bit] ? 2 * w : 0);
    chk(tally[3], c[readout_pkg::ctrl_emb_stats_bit] ? 2 * w : 0);
    chk(32'(order_bad), 32'h0);
    if (!(h && o == readout_pkg::out_second))
    begin
      chk(32'(gains[7:0]), 32'(g[7:0]));
      if (!c[7]) chk(first_px, {8'h0, readout_pkg::first_col, readout_pkg::first_row});
    end
    if (h && o == readout_pkg::out_both) chk(32'(gains[15:8]), 32'(g[15:8]));
  endtask : check_frame
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // watchdog
  initial
  begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h5c624664));
    {psel, penable, pwrite, fire, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 12'h040, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    g = $urandom;
    apb(1'b1, readout_pkg::ctx_addr_addr, 32'hff);
    apb(1'b1, readout_pkg::ctx_data_addr, {16'h0, g[15:0]});
    apb(1'b1, readout_pkg::ctx_data_addr, {16'h0, g[31:16]});
    apb(1'b1, readout_pkg::ctx_addr_addr, 32'hff);
    apb(1'b0, readout_pkg::ctx_data_addr, 32'h0);
    chk(rd & 32'hffff, {16'h0, g[15:0]});
    apb(1'b1, readout_pkg::ctx_addr_addr, 32'h0);
    apb(1'b0, readout_pkg::ctx_data_addr, 32'h0);
    chk(rd & 32'hffff, {16'h0, g[31:16]});
    g = $urandom;
    g = {16'h0, g[15:8] | 8'h10, g[7:0] | 8'h10};
    apb(1'b1, readout_pkg::gain_a_addr, g);
    apb(1'b0, readout_pkg::gain_a_addr, 32'h0);
    chk(rd, g);
    apb(1'b1, readout_pkg::dgain_a_addr, {4{g[7:0]}});
    apb(1'b0, readout_pkg::dgain_a_addr, 32'h0);
    chk(rd, {4{g[7:0]}});
    foreach (modes[i])
    begin
      apb(1'b1, readout_pkg::ctrl_addr, modes[i]);
      wait_frames(1);
      check_frame(modes[i]);
      stop();
    end
    f = frames;
    apb(1'b1, readout_pkg::ctrl_addr, 32'h401);
    repeat (300) @(negedge pclk);
    chk(frames - f, 0);
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    wait_frames(1);
    chk(frames - f, 1);
    stop();
    f = frames;
    apb(1'b1, readout_pkg::ctrl_addr, 32'h2800);
    wait_frames(1);
    repeat (3000) @(negedge pclk);
    chk(frames - f, 1);
    stop();
    apb(1'b1, readout_pkg::frame_b_addr, 32'h0010_0004);
    apb(1'b1, readout_pkg::ctrl_addr, 32'h1);
    wait_frames(1);
    for (int d = 0; d < 2; d++)
    begin
      repeat (20) @(negedge pclk);
      apb(1'b1, readout_pkg::ctrl_addr, d ? 32'h1 : 32'h1001);
      exp_q = d ? '{64, 64, 128} : '{128, 128, 64};
      repeat (3)
      begin
        wait_frames(1);
        chk(tally[0], exp_q.pop_front());
      end
    end
    stop();
    print_verdict();
  end
endmodule : tb_frame_readout_context_control
